/* rtl/fpc_consts.svh */
/*
 constants of the pad, carry and cassette micro sequencer.
 assumes a 100 MHz system clock and a 4 MHz sequencer period.
*/
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH
// timing: one sequencer period and the system clock period, in ns
`define FPC_STEP_NS 250
`define FPC_CLK_NS 10
`define FPC_STEP_CYC (`FPC_STEP_NS / `FPC_CLK_NS)
`define FPC_STEP_LAST 5'(`FPC_STEP_CYC - 1)
`define FPC_STEP_HALF 5'(`FPC_STEP_CYC / 2)
// last period index of each micro
`define FPC_SWAP_LAST 4'h9
`define FPC_ADD_LAST 4'h3
`define FPC_SHORT_LAST 4'h1
// sequencer steps inside one pass
`define FPC_PASS_LEN 4'h5
`define FPC_S0 3'h0
`define FPC_S1 3'h1
`define FPC_S2 3'h2
`define FPC_S3 3'h3
`define FPC_S4 3'h4
`define FPC_MASK24 24'hff_ffff
// operand bit positions
`define FPC_OP_SUB 4
`define FPC_OP_CMP 3
`define FPC_OP_ADC 2
`define FPC_OP_SET 1
`define FPC_OP_CLR 0
`define FPC_TAPE_HI 3
`define FPC_TAPE_LO 1
// tape action codes
`define FPC_TAPE_COND 3'h2
`define FPC_TAPE_STOP 3'h1
`define FPC_TAPE_START 3'h0
// register byte offsets
`define FPC_A_CMD 8'h00
`define FPC_A_STAT 8'h04
`define FPC_A_FA 8'h08
`define FPC_A_FB 8'h0c
`define FPC_A_X 8'h10
`define FPC_A_Y 8'h14
`define FPC_A_SEL 8'h18
`define FPC_A_MODE 8'h1c
`define FPC_PG_LPAD 4'h2
`define FPC_PG_RPAD 4'h3
// status bit positions
`define FPC_ST_BUSY 0
`define FPC_ST_DPF 1
`define FPC_ST_RUN 2
`define FPC_ST_NEQ 3
`define FPC_ST_CY 7
// bus responses
`define FPC_OKAY 2'h0
`define FPC_SLVERR 2'h2
`endif

/* rtl/fpc_pkg.sv */
/*
 types of the micro sequencer: micro selector and state record.
 assumes fpc_consts.svh is available on the include path.
*/
package fpc_pkg;
   // micro selected by the command register, in code order 0..3
   typedef enum logic [1:0] {
      pad_swap_micro, pad_add_micro, tape_control_micro, carry_set_micro
   } fpc_micro_type;
   // the whole state of the block
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic busy;
      fpc_micro_type micro;
      logic [7:0] operand;
      logic [3:0] step;
      logic [4:0] div;
      logic dpf;
      logic [23:0] fa;
      logic [23:0] fb;
      logic [23:0] x;
      logic [23:0] y;
      logic [23:0] hold;
      logic [23:0] wbuf;
      logic [23:0] tempb;
      logic [3:0][23:0] lpad;
      logic [3:0][23:0] rpad;
      logic [1:0] src;
      logic [1:0] snk;
      logic tape_mode;
      logic run;
      logic cy;
      logic neq;
      logic stop;
      logic start;
      logic cond;
      logic finish;
      logic lmwe;
   } fpc_state_type;
endpackage : fpc_pkg

/* rtl/fpc_sequencer.sv */
/*
 field/pad swap, pad add, tape control and carry set micro sequencer
 with an axi4-lite register slave.
 assumes one 100 MHz clock, async active-low reset, a master that
 keeps axi4-lite valid/ready rules.
*/
// What this block does
// - pad swap holds ten periods exactly
// - swap order: field, source, sink, twice
// - two passes of steps S0 to S4
// - pass flag sets, clears on S0 ends
// - first pass field address, second descriptor
// - S0 loads full 24-bit mask into holder
// - S1 captures field unrotated into holder
// - source pad to buffer, then field
// - holder to buffer, then sink pad
// - same source and sink word works
// - sequencer cleared at last swap period
// - pad add takes four periods
// - left pad to buffer, then temporary
// - operand bit 4 selects subtract
// - adder result written back to field
// - tape control compares, two periods
// - operand bits 3..1 pick tape action
// - stop in tape-load mode halts run
// - compare carry and adder carry formed
// - bits 3,2 enable carry from levels
// - bit 1 sets, bit 0 clears carry
// - carry loads only with micro finish
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_sequencer (
   // clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // axi4-lite write channels
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // axi4-lite read channels
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // cassette commands, one-cycle pulses
   output logic stop_at_gap_o,
   output logic tape_start_o,
   output logic tape_cond_o,
   // processor status
   output logic micro_finish_o,
   output logic local_store_write_strobe_o,
   output logic run_state_o,
   output logic carry_o,
   output logic busy_o
);
   // state register and its next value
   fpc_pkg::fpc_state_type st_reg;
   fpc_pkg::fpc_state_type st_next;
   // decoded helpers
   logic tick;
   logic half;
   logic [2:0] ps;
   logic [23:0] field;
   logic [24:0] xy_sum;
   logic compare_carry;
   logic adder_carry_out;
   logic new_cy;
   logic [32:0] wr_look;
   logic [31:0] wmask;
   logic [31:0] wmrg;
   logic wr_ok;
   logic [32:0] rd_look;

   // register read mux: bit 32 marks a mapped address
   function automatic logic [32:0] rd_word(
      input fpc_pkg::fpc_state_type s,
      input logic [7:0] a
   );
      logic [31:0] v;
      logic hit;
      v = 32'h0000_0000;
      hit = 1'b1;
      if (a[7:4] == `FPC_PG_LPAD) begin
         v[23:0] = s.lpad[a[3:2]];
      end else if (a[7:4] == `FPC_PG_RPAD) begin
         v[23:0] = s.rpad[a[3:2]];
      end else begin
         unique case (a)
            `FPC_A_CMD: v[9:0] = {s.micro, s.operand};
            `FPC_A_STAT: begin
               v[`FPC_ST_BUSY] = s.busy;
               v[`FPC_ST_DPF] = s.dpf;
               v[`FPC_ST_RUN] = s.run;
               v[`FPC_ST_NEQ] = s.neq;
               v[`FPC_ST_CY] = s.cy;
            end
            `FPC_A_FA: v[23:0] = s.fa;
            `FPC_A_FB: v[23:0] = s.fb;
            `FPC_A_X: v[23:0] = s.x;
            `FPC_A_Y: v[23:0] = s.y;
            `FPC_A_SEL: v[3:0] = {s.snk, s.src};
            `FPC_A_MODE: v[0] = s.tape_mode;
            default: hit = 1'b0;
         endcase
      end
      if (a[1:0] != 2'h0) begin
         hit = 1'b0;
      end
      return {hit, v};
   endfunction : rd_word

   // period divider edges and pass step
   assign tick = st_reg.busy && (st_reg.div == `FPC_STEP_LAST);
   assign half = st_reg.busy && (st_reg.div == `FPC_STEP_HALF);
   assign ps = (st_reg.step < `FPC_PASS_LEN) ? st_reg.step[2:0]
             : 3'(st_reg.step - `FPC_PASS_LEN);
   // pass flag picks field address, else descriptor
   assign field = st_reg.dpf ? st_reg.fa : st_reg.fb;
   // x/y compare and adder levels
   assign xy_sum = {1'b0, st_reg.x} + {1'b0, st_reg.y};
   assign adder_carry_out = xy_sum[24];
   assign compare_carry = (st_reg.x < st_reg.y)
      || ((st_reg.x == st_reg.y) && st_reg.cy);
   // carry update, clear applied last so it wins
   always_comb begin
      new_cy = st_reg.cy;
      if (st_reg.operand[`FPC_OP_CMP] && compare_carry) begin
         new_cy = 1'b1;
      end
      if (st_reg.operand[`FPC_OP_ADC] && adder_carry_out) begin
         new_cy = 1'b1;
      end
      if (st_reg.operand[`FPC_OP_SET]) begin
         new_cy = 1'b1;
      end
      if (st_reg.operand[`FPC_OP_CLR]) begin
         new_cy = 1'b0;
      end
   end
   // byte-lane merge of a write into the old word
   assign wr_look = rd_word(st_reg, st_reg.waddr);
   assign wmask = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
                   {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
   assign wmrg = (wr_look[31:0] & ~wmask) | (st_reg.wdata & wmask);
   assign wr_ok = wr_look[32] && !st_reg.busy;
   // read lookup of the requested address, bit 32 marks a hit
   assign rd_look = rd_word(st_reg, araddr_i);

   // next state: bus slave then sequencer
   always_comb begin
      st_next = st_reg;
      st_next.stop = 1'b0;
      st_next.start = 1'b0;
      st_next.cond = 1'b0;
      st_next.finish = 1'b0;
      st_next.lmwe = 1'b0;
      // take write address and data in either order
      if (awvalid_i && st_reg.awready) begin
         st_next.awready = 1'b0;
         st_next.aw_got = 1'b1;
         st_next.waddr = awaddr_i;
      end
      if (wvalid_i && st_reg.wready) begin
         st_next.wready = 1'b0;
         st_next.w_got = 1'b1;
         st_next.wdata = wdata_i;
         st_next.wstrb = wstrb_i;
      end
      // both halves held: perform the write and answer
      if (st_reg.aw_got && st_reg.w_got) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = wr_look[32] ? `FPC_OKAY : `FPC_SLVERR;
         if (wr_ok) begin
            // command write starts a micro when running
            if (st_reg.waddr == `FPC_A_CMD && st_reg.run) begin
               st_next.busy = 1'b1;
               st_next.micro = fpc_pkg::fpc_micro_type'(wmrg[9:8]);
               st_next.operand = wmrg[7:0];
               st_next.step = 4'h0;
               st_next.div = 5'h00;
            end
            if (st_reg.waddr == `FPC_A_FA) begin
               st_next.fa = wmrg[23:0];
            end
            if (st_reg.waddr == `FPC_A_FB) begin
               st_next.fb = wmrg[23:0];
            end
            if (st_reg.waddr == `FPC_A_X) begin
               st_next.x = wmrg[23:0];
            end
            if (st_reg.waddr == `FPC_A_Y) begin
               st_next.y = wmrg[23:0];
            end
            if (st_reg.waddr == `FPC_A_SEL) begin
               st_next.src = wmrg[1:0];
               st_next.snk = wmrg[3:2];
            end
            // mode bit 0 tape-load, bit 1 restarts the run flag
            if (st_reg.waddr == `FPC_A_MODE) begin
               st_next.tape_mode = wmrg[0];
               if (wmrg[1]) begin
                  st_next.run = 1'b1;
               end
            end
            if (st_reg.waddr[7:4] == `FPC_PG_LPAD) begin
               st_next.lpad[st_reg.waddr[3:2]] = wmrg[23:0];
            end
            if (st_reg.waddr[7:4] == `FPC_PG_RPAD) begin
               st_next.rpad[st_reg.waddr[3:2]] = wmrg[23:0];
            end
         end
      end
      // response taken: reopen the write channels
      if (st_reg.bvalid && bready_i) begin
         st_next.bvalid = 1'b0;
         st_next.awready = 1'b1;
         st_next.wready = 1'b1;
      end
      // read: answer one cycle after the address
      if (arvalid_i && st_reg.arready) begin
         st_next.arready = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rdata = rd_look[31:0];
         st_next.rresp = rd_look[32] ? `FPC_OKAY : `FPC_SLVERR;
      end
      if (st_reg.rvalid && rready_i) begin
         st_next.rvalid = 1'b0;
         st_next.arready = 1'b1;
      end
      // sequencer: one step per 4 MHz period
      if (st_reg.busy) begin
         st_next.div = st_reg.div + 5'h01;
         // mid S4: holder loaded into the write buffer
         if (half && st_reg.micro == fpc_pkg::pad_swap_micro
             && ps == `FPC_S4) begin
            st_next.wbuf = st_reg.hold;
         end
         if (tick) begin
            st_next.div = 5'h00;
            st_next.step = st_reg.step + 4'h1;
            unique case (st_reg.micro)
               fpc_pkg::pad_swap_micro: begin
                  unique case (ps)
                     `FPC_S0: begin
                        // full mask through exchange bus
                        st_next.hold = `FPC_MASK24;
                        // set after first S0, clear after second
                        st_next.dpf = (st_reg.step == 4'h0);
                     end
                     `FPC_S1: begin
                        // field unrotated under full mask
                        st_next.hold = st_reg.hold & field;
                     end
                     `FPC_S2: begin
                        // source word into the write buffer
                        st_next.wbuf = st_reg.dpf
                           ? st_reg.lpad[st_reg.src]
                           : st_reg.rpad[st_reg.src];
                     end
                     `FPC_S3: begin
                        st_next.lmwe = 1'b1;
                        if (st_reg.dpf) begin
                           st_next.fa = st_reg.wbuf;
                        end else begin
                           st_next.fb = st_reg.wbuf;
                        end
                     end
                     `FPC_S4: begin
                        // old field came from the holder, so a
                        // shared source/sink word stays correct
                        st_next.lmwe = 1'b1;
                        if (st_reg.dpf) begin
                           st_next.lpad[st_reg.snk] = st_reg.wbuf;
                        end else begin
                           st_next.rpad[st_reg.snk] = st_reg.wbuf;
                        end
                     end
                     default: begin
                     end
                  endcase
                  // last period: clear sequencer and finish
                  if (st_reg.step == `FPC_SWAP_LAST) begin
                     st_next.busy = 1'b0;
                     st_next.step = 4'h0;
                     st_next.finish = 1'b1;
                  end
               end
               fpc_pkg::pad_add_micro: begin
                  unique case (st_reg.step[1:0])
                     2'h0: st_next.wbuf = st_reg.lpad[st_reg.src];
                     2'h1: begin
                        st_next.tempb = st_reg.wbuf;
                        st_next.lmwe = 1'b1;
                     end
                     2'h2: begin
                        st_next.wbuf = st_reg.operand[`FPC_OP_SUB]
                           ? st_reg.fa - st_reg.tempb
                           : st_reg.fa + st_reg.tempb;
                     end
                     2'h3: begin
                        st_next.fa = st_reg.wbuf;
                        st_next.lmwe = 1'b1;
                     end
                  endcase
                  if (st_reg.step == `FPC_ADD_LAST) begin
                     st_next.busy = 1'b0;
                     st_next.step = 4'h0;
                     st_next.finish = 1'b1;
                  end
               end
               fpc_pkg::tape_control_micro: begin
                  // compare always happens, whatever the variant
                  if (st_reg.step == 4'h0) begin
                     st_next.neq = (st_reg.x != st_reg.y);
                  end else begin
                     st_next.busy = 1'b0;
                     st_next.step = 4'h0;
                     st_next.finish = 1'b1;
                     unique case
                       (st_reg.operand[`FPC_TAPE_HI:`FPC_TAPE_LO])
                        `FPC_TAPE_COND: st_next.cond = st_reg.neq;
                        `FPC_TAPE_STOP: begin
                           st_next.stop = 1'b1;
                           if (st_reg.tape_mode) begin
                              st_next.run = 1'b0;
                           end
                        end
                        `FPC_TAPE_START: st_next.start = 1'b1;
                        default: begin
                        end
                     endcase
                  end
               end
               fpc_pkg::carry_set_micro: begin
                  // carry loaded only with the finish pulse
                  if (st_reg.step == `FPC_SHORT_LAST) begin
                     st_next.busy = 1'b0;
                     st_next.step = 4'h0;
                     st_next.finish = 1'b1;
                     st_next.cy = new_cy;
                  end
               end
            endcase
         end
      end
   end

   // state register, constant reset value
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                    run: 1'b1, micro: fpc_pkg::pad_swap_micro,
                    default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign awready_o = st_reg.awready;
   assign wready_o = st_reg.wready;
   assign bvalid_o = st_reg.bvalid;
   assign bresp_o = st_reg.bresp;
   assign arready_o = st_reg.arready;
   assign rvalid_o = st_reg.rvalid;
   assign rdata_o = st_reg.rdata;
   assign rresp_o = st_reg.rresp;
   assign stop_at_gap_o = st_reg.stop;
   assign tape_start_o = st_reg.start;
   assign tape_cond_o = st_reg.cond;
   assign micro_finish_o = st_reg.finish;
   assign local_store_write_strobe_o = st_reg.lmwe;
   assign run_state_o = st_reg.run;
   assign carry_o = st_reg.cy;
   assign busy_o = st_reg.busy;

   // checks on the sequencer
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_swap_length: assert property (
      $rose(st_reg.busy) && st_reg.micro == fpc_pkg::pad_swap_micro
      |-> ##249 st_reg.busy ##1 !st_reg.busy)
      else $error("pad swap not ten periods");
   a_add_length: assert property (
      $rose(st_reg.busy) && st_reg.micro == fpc_pkg::pad_add_micro
      |-> ##99 st_reg.busy ##1 (!st_reg.busy && st_reg.finish))
      else $error("pad add not four periods");
   a_tape_length: assert property (
      $rose(st_reg.busy) && st_reg.micro == fpc_pkg::tape_control_micro
      |-> ##49 st_reg.busy ##1 (!st_reg.busy
          && st_reg.neq == (st_reg.x != st_reg.y)))
      else $error("tape control wrong");
   a_pass_flag: assert property (
      tick && st_reg.micro == fpc_pkg::pad_swap_micro && ps == `FPC_S0
      |=> st_reg.dpf == ($past(st_reg.step) == 4'h0))
      else $error("pass flag wrong");
   a_hold_field: assert property (
      tick && st_reg.micro == fpc_pkg::pad_swap_micro && ps == `FPC_S1
      |=> st_reg.hold == $past(field))
      else $error("holder missed field");
   a_hold_mask: assert property (
      tick && st_reg.micro == fpc_pkg::pad_swap_micro && ps == `FPC_S0
      |=> st_reg.hold == `FPC_MASK24)
      else $error("mask not full");
   a_field_load: assert property (
      tick && st_reg.micro == fpc_pkg::pad_swap_micro && ps == `FPC_S2
      |=> ##25 (st_reg.dpf ? st_reg.fa : st_reg.fb) == $past(st_reg.wbuf))
      else $error("field not loaded");
   a_sink_write: assert property (
      tick && st_reg.micro == fpc_pkg::pad_swap_micro && ps == `FPC_S4
      && st_reg.dpf |=> st_reg.lpad[st_reg.snk] == $past(st_reg.hold))
      else $error("sink word wrong");
   a_add_result: assert property (
      tick && st_reg.micro == fpc_pkg::pad_add_micro
      && st_reg.step == 4'h2 |=> st_reg.wbuf
      == ($past(st_reg.operand[`FPC_OP_SUB])
      ? $past(st_reg.fa) - $past(st_reg.tempb)
      : $past(st_reg.fa) + $past(st_reg.tempb)))
      else $error("pad add result wrong");
   a_stop_halts: assert property (
      st_reg.stop && $past(st_reg.tape_mode) |-> !st_reg.run)
      else $error("stop did not halt");
   a_cond_neq: assert property (
      st_reg.cond |-> st_reg.neq
      && st_reg.operand[`FPC_TAPE_HI:`FPC_TAPE_LO] == `FPC_TAPE_COND)
      else $error("conditional without inequality");
   a_carry_finish: assert property (
      $changed(st_reg.cy) |-> st_reg.finish
      && st_reg.micro == fpc_pkg::carry_set_micro)
      else $error("carry moved without finish");
   a_carry_clear: assert property (
      st_reg.finish && st_reg.micro == fpc_pkg::carry_set_micro
      && st_reg.operand[`FPC_OP_CLR] |-> !st_reg.cy)
      else $error("carry clear lost");
   c_swap_done: cover property (
      st_reg.finish && st_reg.micro == fpc_pkg::pad_swap_micro);
   c_add_sub: cover property (st_reg.finish
      && st_reg.micro == fpc_pkg::pad_add_micro && st_reg.operand[4]);
   c_halt: cover property (st_reg.stop && !st_reg.run);
endmodule : fpc_sequencer

/* verif/fpc_sequencer_tb.sv */
/*
 self-checking bench of the micro sequencer: bus, swap, add, tape, carry.
 assumes fpc_consts.svh on the include path and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_sequencer_tb;
   // bench drives
   logic clock_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
   logic [7:0] awaddr_i, araddr_i;
   logic [31:0] wdata_i, rd, rdata_o;
   // design outputs
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, busy_o;
   logic [1:0] bresp_o, rresp_o, resp;
   logic stop_at_gap_o, tape_start_o, tape_cond_o, micro_finish_o;
   logic local_store_write_strobe_o, run_state_o, carry_o;
   // counters of checks, busy length and pulses
   int err_total, n_tests, blen, bcnt, n_stp, n_sta, n_cnd, n_fin, n_wr;
   fpc_sequencer u_fpc_sequencer (.clock_i(clock_i), .nrst_i(nrst_i),
      .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
      .wdata_i(wdata_i), .wstrb_i(4'hf), .wvalid_i(wvalid_i),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
      .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
      .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .rvalid_o(rvalid_o), .rready_i(rready_i),
      .stop_at_gap_o(stop_at_gap_o), .tape_start_o(tape_start_o),
      .tape_cond_o(tape_cond_o), .micro_finish_o(micro_finish_o),
      .local_store_write_strobe_o(local_store_write_strobe_o),
      .run_state_o(run_state_o), .carry_o(carry_o), .busy_o(busy_o));
   // free running clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // busy length and pulse counting, sampled at each rising edge
   always @(posedge clock_i) begin
      if (busy_o === 1'b1) bcnt <= bcnt + 1;
      else if (bcnt != 0) begin
         blen <= bcnt;
         bcnt <= 0;
      end
      n_stp <= n_stp + int'(stop_at_gap_o === 1'b1);
      n_sta <= n_sta + int'(tape_start_o === 1'b1);
      n_cnd <= n_cnd + int'(tape_cond_o === 1'b1);
      n_fin <= n_fin + int'(micro_finish_o === 1'b1);
      n_wr <= n_wr + int'(local_store_write_strobe_o === 1'b1);
   end
   // one comparison, counted
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // the only end of the run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // a wait that ran out
   task automatic hang();
      err_total++;
      $display("MISMATCH wait expected answer seen none");
      print_verdict();
   endtask : hang
   // bus write, response kept in resp
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock_i);
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clock_i);
         if (awready_o === 1'b1) awvalid_i <= 1'b0;
         if (wready_o === 1'b1) wvalid_i <= 1'b0;
         if (bvalid_o === 1'b1) break;
      end
      if (i == 50) hang();
      resp = bresp_o;
      bready_i <= 1'b0;
   endtask : axw
   // bus read into rd and resp
   task automatic axr(input logic [7:0] a);
      int i;
      @(posedge clock_i);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clock_i);
         if (arready_o === 1'b1) arvalid_i <= 1'b0;
         if (rvalid_o === 1'b1) break;
      end
      if (i == 50) hang();
      rd = rdata_o;
      resp = rresp_o;
      rready_i <= 1'b0;
   endtask : axr
   // read a word and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk("word", rd, e);
   endtask : rchk
   // wait for the micro to end, then compare its busy length
   task automatic fin(input int len);
      int i;
      int f0;
      f0 = n_fin;
      for (i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge clock_i);
      if (i == 400) hang();
      @(posedge clock_i);
      #1;
      chk("busy length", blen, len);
      chk("finish", n_fin - f0, 1);
   endtask : fin
   // one tape control run with expected pulse counts
   task automatic tape(input logic [23:0] y, input logic [2:0] c,
      input int ec, es, et);
      int c0, s0, t0, f0;
      axw(`FPC_A_Y, {8'h00, y});
      c0 = n_cnd;
      s0 = n_stp;
      t0 = n_sta;
      f0 = n_fin;
      axw(`FPC_A_CMD, {22'h0, 2'h2, 4'h0, c, 1'b0});
      fin(50);
      chk("cond", n_cnd - c0, ec);
      chk("stop", n_stp - s0, es);
      chk("start", n_sta - t0, et);
      chk("finish", n_fin - f0, 1);
   endtask : tape
   // one carry set run; flag must hold until finish
   task automatic cy(input logic [23:0] x, y, input logic [7:0] op,
      input logic e);
      logic old;
      axw(`FPC_A_X, {8'h00, x});
      axw(`FPC_A_Y, {8'h00, y});
      old = carry_o;
      axw(`FPC_A_CMD, {22'h0, 2'h3, op});
      repeat (40) @(posedge clock_i);
      chk("carry early", carry_o, old);
      fin(50);
      chk("carry", carry_o, e);
   endtask : cy
   // unmapped place refused on both channels
   task automatic refuse_run();
      axw(8'h40, 32'h0000_0001);
      chk("bresp", resp, `FPC_SLVERR);
      axr(8'h40);
      chk("rresp", resp, `FPC_SLVERR);
   endtask : refuse_run
   // swap with source and sink the same word on both sides
   task automatic swap_run();
      int w0;
      axw(`FPC_A_FA, 32'h0011_1111);
      axw(`FPC_A_FB, 32'h0022_2222);
      axw(8'h24, 32'h00aa_aaaa);
      axw(8'h34, 32'h00bb_bbbb);
      axw(`FPC_A_SEL, 32'h0000_0005);
      w0 = n_wr;
      axw(`FPC_A_CMD, 32'h0000_0000);
      repeat (40) @(posedge clock_i);
      axr(`FPC_A_STAT);
      chk("pass flag", rd[`FPC_ST_DPF], 1'b1);
      fin(250);
      chk("swap writes", n_wr - w0, 4);
      axr(`FPC_A_STAT);
      chk("pass flag", rd[`FPC_ST_DPF], 1'b0);
      rchk(`FPC_A_FA, 32'h00aa_aaaa);
      rchk(8'h24, 32'h0011_1111);
      rchk(`FPC_A_FB, 32'h00bb_bbbb);
      rchk(8'h34, 32'h0022_2222);
   endtask : swap_run
   // pad add: subtract with wrap, then add back
   task automatic add_run();
      axw(`FPC_A_FA, 32'h0000_0001);
      axw(8'h28, 32'h0000_0003);
      axw(`FPC_A_SEL, 32'h0000_0002);
      axw(`FPC_A_CMD, 32'h0000_0110);
      fin(100);
      rchk(`FPC_A_FA, 32'h00ff_fffe);
      axw(`FPC_A_CMD, 32'h0000_0100);
      fin(100);
      rchk(`FPC_A_FA, 32'h0000_0001);
   endtask : add_run
   // main sequence
   initial begin
      nrst_i = 1'b0;
      awvalid_i = 1'b0;
      wvalid_i = 1'b0;
      bready_i = 1'b0;
      arvalid_i = 1'b0;
      rready_i = 1'b0;
      awaddr_i = 8'h00;
      araddr_i = 8'h00;
      wdata_i = 32'h0000_0000;
      repeat (3) @(posedge clock_i);
      nrst_i <= 1'b1;
      #1;
      chk("run after reset", run_state_o, 1'b1);
      refuse_run();
      swap_run();
      add_run();
      // tape actions: conditional, stop, start and unused code 7
      axw(`FPC_A_X, 32'h0000_0005);
      tape(24'h00_0007, `FPC_TAPE_COND, 1, 0, 0);
      tape(24'h00_0005, `FPC_TAPE_COND, 0, 0, 0);
      tape(24'h00_0007, `FPC_TAPE_STOP, 0, 1, 0);
      tape(24'h00_0007, `FPC_TAPE_START, 0, 0, 1);
      tape(24'h00_0007, 3'h7, 0, 0, 0);
      chk("run", run_state_o, 1'b1);
      axw(`FPC_A_MODE, 32'h0000_0001);
      tape(24'h00_0007, `FPC_TAPE_STOP, 0, 1, 0);
      chk("halted", run_state_o, 1'b0);
      axw(`FPC_A_MODE, 32'h0000_0002);
      // carry set cases
      cy(24'h00_0005, 24'h00_0007, 8'h08, 1'b1);
      cy(24'h00_0005, 24'h00_0007, 8'h01, 1'b0);
      cy(24'h00_0005, 24'h00_0005, 8'h08, 1'b0);
      cy(24'h00_0005, 24'h00_0005, 8'h02, 1'b1);
      cy(24'h00_0005, 24'h00_0005, 8'h00, 1'b1);
      cy(24'h00_0005, 24'h00_0005, 8'h01, 1'b0);
      cy(24'h00_0005, 24'h00_0007, 8'h04, 1'b0);
      cy(24'hff_ffff, 24'h00_0001, 8'h04, 1'b1);
      cy(24'h00_0005, 24'h00_0007, 8'h0b, 1'b0);
      print_verdict();
   end
endmodule : fpc_sequencer_tb
